/* File: include/rtt_pkg.sv */
// Constants, register map and length decode for the rate trim block
package rtt_pkg;

  // Clock and oscillator
  localparam int unsigned RTT_CLK_PERIOD_NS  = 32'h0000_0014;
  localparam int unsigned RTT_NS_PER_US      = 32'h0000_03E8;
  localparam int unsigned RTT_OSC_HZ         = 32'h0000_8000;

  // Oscillator halt timeout, microseconds, and its clock count
  localparam int unsigned RTT_HALT_TIMEOUT_US = 32'h0000_0064;
  localparam int unsigned RTT_HALT_CYCLES     =
    (RTT_HALT_TIMEOUT_US * RTT_NS_PER_US) / RTT_CLK_PERIOD_NS;

  // Timebase
  localparam logic [15:0] RTT_SEC_LEN_BASE   = 16'(RTT_OSC_HZ);
  localparam logic [4:0]  RTT_WINDOW_LAST    = 5'h13;
  localparam logic [4:0]  RTT_WINDOW_FIRST   = 5'h00;

  // Register offsets
  localparam logic [7:0]  RTT_ADDR_TRIM      = 8'h00;
  localparam logic [7:0]  RTT_ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  RTT_ADDR_SECONDS   = 8'h08;

  // Field layout
  localparam int unsigned RTT_TRIM_W         = 32'h0000_0007;
  localparam int unsigned RTT_STAT_HALT_BIT  = 32'h0000_0000;
  localparam int unsigned RTT_STAT_IDX_LSB   = 32'h0000_0008;

  // Reset values
  localparam logic [6:0]  RTT_TRIM_RST       = 7'h00;
  localparam logic        RTT_HALT_RST       = 1'b1;

  // Special codes
  localparam logic [6:0]  RTT_CODE_PLUS1     = 7'h01;
  localparam logic [6:0]  RTT_CODE_MINUS63   = 7'h41;

  // Oscillator cycles per second for a given trim code
  function automatic logic [15:0] rtt_trim_len_f(input logic [6:0] code);
    logic [5:0]  mag;
    logic [15:0] delta;
    mag = 6'h00;
    if (code[5:0] == 6'h00 || code == RTT_CODE_PLUS1 || code == RTT_CODE_MINUS63) begin
      mag = 6'h00;
    end else if (!code[6]) begin
      mag = 6'(code[5:0] - 6'h01);
    end else begin
      mag = 6'(7'h00 - code);
    end
    delta = {9'h000, mag, 1'b0};
    if (!code[6]) begin
      return 16'(RTT_SEC_LEN_BASE + delta);
    end
    return 16'(RTT_SEC_LEN_BASE - delta);
  endfunction

endpackage

/* File: include/rtt_tick_if.sv */
// Link between the trim control and the second generator
`timescale 1ns/1ns
interface rtt_tick_if #(
  parameter int W = 16
);
  logic         osc_edge;
  logic         restart;
  logic [W-1:0] sec_len;
  logic         sec_tick;

  modport ctrl (output osc_edge, output restart, output sec_len, input sec_tick);
  modport gen  (input osc_edge, input restart, input sec_len, output sec_tick);
endinterface

/* File: sim/rtt_rate_trim_tb.sv */
// Self-checking bench for the rate trim block
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module rtt_rate_trim_tb;
  import rtt_pkg::*;
  localparam int unsigned HALT_N = 64;
  // Design signals
  logic        clk;
  logic        rst;
  logic        ce;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        osc_clk_in;
  logic        clock_out_gate_pin;
  logic        raw_clock_out_pin;
  logic        sec_tick_out;
  logic        osc_halt_flag;
  // Bench state
  int          n_errors;
  int          checks;
  int          m_trim;
  int          m_halt;
  int          osc_cnt;
  int          osc_rise;
  logic        osc_run;
  logic        osc_fast;
  logic        raw_chk;
  logic [2:0]  hist;
  logic [15:0] rng_reg;
  logic [6:0]  code_tbl [8] = '{7'h00, 7'h40, 7'h01, 7'h41, 7'h02, 7'h3F, 7'h7F, 7'h42};

  rtt_rate_trim #(.HALT_CYCLES(HALT_N)) u_rtt_rate_trim (
    .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_clk_in(osc_clk_in),
    .clock_out_gate_pin(clock_out_gate_pin), .raw_clock_out_pin(raw_clock_out_pin),
    .sec_tick_out(sec_tick_out), .osc_halt_flag(osc_halt_flag));

  always #10 clk = ~clk;

  function automatic logic [15:0] lfsr_f(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Oscillator stand-in, 12 or 2 clocks a period, held low when stopped
  // Rises counted since the last stop, where the second restarts
  always @(posedge clk) begin
    if (osc_run) begin
      osc_cnt    <= (osc_cnt == 11) ? 0 : osc_cnt + 1;
      osc_clk_in <= osc_fast ? !osc_clk_in : (osc_cnt < 6);
      if (!osc_clk_in && (osc_fast || osc_cnt < 6)) begin
        osc_rise <= osc_rise + 1;
      end
    end else begin
      osc_clk_in <= 1'b0;
      osc_rise   <= 0;
    end
  end

  // Raw clock output model, three clocks behind the pins
  always @(posedge clk) hist <= {hist[1:0], osc_clk_in & clock_out_gate_pin};
  always @(negedge clk) begin
    if (raw_chk) begin
      `CHK(raw_clock_out_pin, hist[2])
      `CHK(sec_tick_out, 1'b0)
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    `CHK(reg_rdata, exp)
    @(posedge clk);
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    report_and_stop;
  end

  initial begin
    int i;
    clk = 1'b0; rst = 1'b1; ce = 1'b1; reg_addr = 8'h00; reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0; reg_rd = 1'b0; osc_clk_in = 1'b0; clock_out_gate_pin = 1'b0;
    osc_run = 1'b0; raw_chk = 1'b0; osc_cnt = 0; hist = 3'h0; n_errors = 0; checks = 0;
    rng_reg = 16'hB43E; m_trim = 0; m_halt = 1;
    osc_fast = 1'b0; osc_rise = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(RTT_ADDR_STATUS, 32'(m_halt));
    rd_chk(RTT_ADDR_TRIM, 32'(m_trim));
    osc_run <= 1'b1;
    clock_out_gate_pin <= 1'b1;
    repeat (8) @(posedge clk);
    raw_chk <= 1'b1;
    wr(RTT_ADDR_STATUS, 32'h0000_0000);
    m_halt = 0;
    wr(RTT_ADDR_STATUS, 32'h0000_0001);
    rd_chk(RTT_ADDR_STATUS, 32'(m_halt));
    rd_chk(8'h0C, 32'h0000_0000);
    // Special codes, range ends, then random codes with gate toggling
    for (i = 0; i < 16; i++) begin
      rng_reg = lfsr_f(rng_reg);
      m_trim  = (i < 8) ? int'(code_tbl[i]) : int'(rng_reg[6:0]);
      clock_out_gate_pin <= rng_reg[8];
      wr(RTT_ADDR_TRIM, 32'(m_trim));
      rd_chk(RTT_ADDR_TRIM, 32'(m_trim));
      rd_chk(RTT_ADDR_SECONDS, 32'h0000_0000);
    end
    // Oscillator stall sets the flag and clears the code
    wr(RTT_ADDR_TRIM, 32'h0000_0009);
    osc_run <= 1'b0;
    for (i = 0; i < 4 * HALT_N && osc_halt_flag !== 1'b1; i++) @(posedge clk);
    m_halt = 1;
    m_trim = 0;
    `CHK(osc_halt_flag, 1'(m_halt))
    rd_chk(RTT_ADDR_TRIM, 32'(m_trim));
    rd_chk(RTT_ADDR_STATUS, 32'(m_halt));
    osc_run <= 1'b1;
    clock_out_gate_pin <= 1'b1;
    repeat (20) @(posedge clk);
    wr(RTT_ADDR_STATUS, 32'h0000_0000);
    m_halt = 0;
    wr(RTT_ADDR_TRIM, 32'h0000_0057);
    rd_chk(RTT_ADDR_TRIM, 32'h0000_0057);
    rd_chk(RTT_ADDR_STATUS, 32'(m_halt));
    // Clock enable low drops a write and freezes the raw clock
    raw_chk <= 1'b0;
    ce      <= 1'b0;
    wr(RTT_ADDR_TRIM, 32'h0000_0000);
    ce      <= 1'b1;
    rd_chk(RTT_ADDR_TRIM, 32'h0000_0057);
    // A plain second on a fast oscillator; the new code waits for the next window
    osc_fast <= 1'b1;
    for (i = 0; i < 70000 && sec_tick_out !== 1'b1; i++) @(negedge clk);
    `CHK(sec_tick_out, 1'b1)
    // Two more rises pass while the last edge crosses the synchroniser
    `CHK(osc_rise, int'(RTT_SEC_LEN_BASE) + 2)
    @(negedge clk);
    `CHK(sec_tick_out, 1'b0)
    @(posedge clk);
    rd_chk(RTT_ADDR_SECONDS, 32'h0000_0001);
    rd_chk(RTT_ADDR_STATUS, 32'((1 << RTT_STAT_IDX_LSB) | m_halt));
    repeat (30) @(posedge clk);
    report_and_stop;
  end
endmodule // rtt_rate_trim_tb

/* File: verilog/rtt_rate_trim.sv */
// Rate trim of the one-second timebase from the crystal oscillator
// How it works
// - One second out of every twenty-second window has its length in oscillator cycles changed.
// - A code whose six low bits are zero gives no change, whatever the sign bit.
// - Signed values 0, +1, -64 and -63 leave every second at its plain length.
// - Codes 2 to 63 lengthen the corrected second by two cycles per step to slow a fast clock.
// - Codes 127 down to 66 shorten the corrected second by two cycles per step for a slow clock.
// - The raw clock output follows the oscillator, untouched by the trim.
// - The raw clock output runs only while the gate pin is high.
// - Setting the halt flag, at reset or on a stopped oscillator, clears the trim code.
`timescale 1ns/1ns
module rtt_rate_trim
  import rtt_pkg::*;
#(
  parameter int          CNT_W       = 16,
  parameter int          WD_W        = 16,
  parameter int unsigned HALT_CYCLES = RTT_HALT_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Oscillator and clock output pins
  input  wire logic        osc_clk_in,
  input  wire logic        clock_out_gate_pin,
  output logic             raw_clock_out_pin,
  // Timebase and status
  output logic             sec_tick_out,
  output logic             osc_halt_flag
);

  // Synchronisers
  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic gate_s1;
  logic gate_s2;
  logic osc_edge;

  // Halt detection
  logic [WD_W-1:0] wd_reg;
  logic            halt_set;

  // Trim state
  logic [6:0]       trim_code_reg;
  logic [6:0]       trim_snap_reg;
  logic [4:0]       idx_reg;
  logic [CNT_W-1:0] sec_len_reg;
  logic [31:0]      seconds_reg;
  logic             tick;

  // Bus decode
  logic wr_trim;
  logic wr_status;

  rtt_tick_if #(.W(CNT_W)) tick_bus ();

  rtt_sec_gen #(.W(CNT_W)) u_sec_gen (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .tb  (tick_bus)
  );

  assign tick_bus.osc_edge = osc_edge;
  assign tick_bus.restart  = halt_set;
  assign tick_bus.sec_len  = sec_len_reg;
  assign tick              = tick_bus.sec_tick;

  assign wr_trim   = reg_wr && reg_addr == RTT_ADDR_TRIM;
  assign wr_status = reg_wr && reg_addr == RTT_ADDR_STATUS;

  // Pin synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_s1  <= 1'b0;
      osc_s2  <= 1'b0;
      osc_s3  <= 1'b0;
      gate_s1 <= 1'b0;
      gate_s2 <= 1'b0;
    end else if (ce) begin
      osc_s1  <= osc_clk_in;
      osc_s2  <= osc_s1;
      osc_s3  <= osc_s2;
      gate_s1 <= clock_out_gate_pin;
      gate_s2 <= gate_s1;
    end
  end

  assign osc_edge = osc_s2 & ~osc_s3;

  // Raw clock output, gated only by the pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      raw_clock_out_pin <= 1'b0;
    end else if (ce) begin
      raw_clock_out_pin <= osc_s2 & gate_s2;
    end
  end

  // Oscillator watchdog
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_reg <= '0;
    end else if (ce) begin
      if (osc_edge) begin
        wd_reg <= '0;
      end else if (!halt_set) begin
        wd_reg <= WD_W'(wd_reg + WD_W'(1));
      end
    end
  end

  assign halt_set = (wd_reg == WD_W'(HALT_CYCLES - 1)) && !osc_edge;

  // Halt flag, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_halt_flag <= RTT_HALT_RST;
    end else if (ce) begin
      if (halt_set) begin
        osc_halt_flag <= 1'b1;
      end else if (wr_status && !reg_wdata[RTT_STAT_HALT_BIT]) begin
        osc_halt_flag <= 1'b0;
      end
    end
  end

  // Trim code register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trim_code_reg <= RTT_TRIM_RST;
    end else if (ce) begin
      if (halt_set) begin
        trim_code_reg <= RTT_TRIM_RST;
      end else if (wr_trim) begin
        trim_code_reg <= reg_wdata[RTT_TRIM_W-1:0];
      end
    end
  end

  // Window position and code snapshot per window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_reg       <= RTT_WINDOW_FIRST;
      trim_snap_reg <= RTT_TRIM_RST;
    end else if (ce) begin
      if (halt_set) begin
        idx_reg       <= RTT_WINDOW_FIRST;
        trim_snap_reg <= RTT_TRIM_RST;
      end else if (tick) begin
        if (idx_reg == RTT_WINDOW_LAST) begin
          idx_reg       <= RTT_WINDOW_FIRST;
          trim_snap_reg <= trim_code_reg;
        end else begin
          idx_reg <= 5'(idx_reg + 5'h01);
        end
      end
    end
  end

  // Length of the running second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_len_reg <= CNT_W'(RTT_SEC_LEN_BASE);
    end else if (ce) begin
      if (idx_reg == RTT_WINDOW_FIRST) begin
        sec_len_reg <= CNT_W'(rtt_trim_len_f(trim_snap_reg));
      end else begin
        sec_len_reg <= CNT_W'(RTT_SEC_LEN_BASE);
      end
    end
  end

  // Seconds count and tick output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seconds_reg  <= 32'h0000_0000;
      sec_tick_out <= 1'b0;
    end else if (ce) begin
      sec_tick_out <= tick;
      if (tick) begin
        seconds_reg <= 32'(seconds_reg + 32'h0000_0001);
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          RTT_ADDR_TRIM: begin
            reg_rdata <= {25'h000_0000, trim_code_reg};
          end
          RTT_ADDR_STATUS: begin
            reg_rdata[RTT_STAT_HALT_BIT] <= osc_halt_flag;
            reg_rdata[RTT_STAT_IDX_LSB +: 5] <= idx_reg;
          end
          RTT_ADDR_SECONDS: begin
            reg_rdata <= seconds_reg;
          end
          default: begin
            reg_rdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence halt_s;
    ce && halt_set;
  endsequence

  sequence wrap_s;
    ce && tick && !halt_set && idx_reg == RTT_WINDOW_LAST;
  endsequence

  sequence first_sec_s;
    ce && idx_reg == RTT_WINDOW_FIRST;
  endsequence

  halt_clears_code_a: assert property (
    halt_s |=> trim_code_reg == 7'h00 && trim_snap_reg == 7'h00 && osc_halt_flag)
    else $error("halt did not clear trim code");

  halt_flag_hold_a: assert property (
    ce && osc_halt_flag && !wr_status |=> osc_halt_flag)
    else $error("halt flag dropped without a write");

  zero_code_a: assert property (
    first_sec_s and (trim_snap_reg[5:0] == 6'h00) |=> sec_len_reg == RTT_SEC_LEN_BASE)
    else $error("zero code changed second length");

  off_codes_a: assert property (
    first_sec_s and (trim_snap_reg == 7'h01 || trim_snap_reg == 7'h41)
    |=> sec_len_reg == RTT_SEC_LEN_BASE)
    else $error("disabled code changed second length");

  fast_osc_a: assert property (
    first_sec_s and (!trim_snap_reg[6] && trim_snap_reg[5:1] != 5'h00)
    |=> sec_len_reg == 16'(RTT_SEC_LEN_BASE
                          + 16'({$past(trim_snap_reg) - 7'h01, 1'b0})))
    else $error("fast oscillator second length wrong");

  slow_osc_a: assert property (
    first_sec_s and (trim_snap_reg[6] && trim_snap_reg[5:1] != 5'h00)
    |=> sec_len_reg == 16'(RTT_SEC_LEN_BASE
                          - 16'({7'h00 - $past(trim_snap_reg), 1'b0})))
    else $error("slow oscillator second length wrong");

  plain_sec_a: assert property (
    ce && idx_reg != RTT_WINDOW_FIRST |=> sec_len_reg == RTT_SEC_LEN_BASE)
    else $error("uncorrected second has wrong length");

  window_wrap_a: assert property (
    wrap_s |=> idx_reg == RTT_WINDOW_FIRST && trim_snap_reg == $past(trim_code_reg))
    else $error("window did not wrap after twenty seconds");

  gate_low_a: assert property (
    ce && !gate_s2 |=> !raw_clock_out_pin)
    else $error("raw clock driven while gate low");

  raw_follow_a: assert property (
    ce && gate_s2 && osc_s2 ##1 ce && gate_s2 && !osc_s2 |-> raw_clock_out_pin ##1 !raw_clock_out_pin)
    else $error("raw clock does not follow oscillator");

  sequence tick_s;
    ce && tick && !halt_set;
  endsequence

  tick_out_a: assert property (
    ce && tick |=> sec_tick_out)
    else $error("second tick not forwarded");

  idx_step_a: assert property (
    tick_s ##0 idx_reg != RTT_WINDOW_LAST |=> idx_reg == 5'($past(idx_reg) + 5'h01))
    else $error("window index did not advance");

  idx_range_a: assert property (
    idx_reg <= RTT_WINDOW_LAST)
    else $error("window index out of range");

  ce_freeze_a: assert property (
    !ce |=> $stable(trim_code_reg) && $stable(idx_reg) && $stable(osc_halt_flag))
    else $error("state moved while clock enable low");

  rdata_idle_a: assert property (
    ce && !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not cleared after read");

endmodule // rtt_rate_trim

/* File: verilog/rtt_sec_gen.sv */
// Counts oscillator edges into seconds of programmable length
`timescale 1ns/1ns
module rtt_sec_gen #(
  parameter int W = 16
) (
  // Clock, reset and enable
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Control link
  rtt_tick_if.gen   tb
);

  logic [W-1:0] cnt_reg;
  logic         tick_reg;

  // Edge counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (ce) begin
      tick_reg <= 1'b0;
      if (tb.restart) begin
        cnt_reg <= '0;
      end else if (tb.osc_edge) begin
        if (cnt_reg == W'(tb.sec_len - W'(1))) begin
          cnt_reg  <= '0;
          tick_reg <= 1'b1;
        end else begin
          cnt_reg <= W'(cnt_reg + W'(1));
        end
      end
    end
  end

  assign tb.sec_tick = tick_reg;

endmodule // rtt_sec_gen
